// *** common/dbtp_pkg.sv ***
// package for the dual byte timer: register map, field layouts and constants
package dbtp_pkg;

  // ==========================================================
  // register indices; byte address is four times the index
  localparam logic [15:0] DBTP_IDX_CTRL = 16'hfe18;
  localparam logic [15:0] DBTP_IDX_PRESC = 16'hfe19;
  localparam logic [15:0] DBTP_IDX_LCNT = 16'hfe1a;
  localparam logic [15:0] DBTP_IDX_HCNT = 16'hfe1b;
  localparam logic [15:0] DBTP_IDX_LDATA = 16'hfe1c;
  localparam logic [15:0] DBTP_IDX_HDATA = 16'hfe1d;
  localparam logic [15:0] DBTP_IDX_EVSEL = 16'hfe1e;

  // ==========================================================
  // values after reset
  localparam logic [7:0] DBTP_CTRL_RST = 8'h00;
  localparam logic [7:0] DBTP_PRESC_RST = 8'h00;
  localparam logic [7:0] DBTP_DATA_RST = 8'h00;
  localparam logic [7:0] DBTP_CNT_RST = 8'h00;
  localparam logic DBTP_EVSEL_RST = 1'b0;

  // ==========================================================
  // field positions and special values
  localparam int DBTP_EVSEL_BIT = 0;
  localparam logic [7:0] DBTP_DATA_FULL = 8'hff;
  localparam logic [1:0] DBTP_RESP_OKAY = 2'b00;
  localparam logic [1:0] DBTP_RESP_SLVERR = 2'b10;

  // ==========================================================
  // timer_control layout, bit 7 first
  typedef struct packed {
    logic high_run;
    logic low_run;
    logic cascade_select;
    logic pwm_select;
    logic high_zero_flag;
    logic high_irq_enable;
    logic low_zero_flag;
    logic low_irq_enable;
  } dbtp_ctrl_s;

  // prescaler_select layout, bit 7 first
  typedef struct packed {
    logic high_prescale_enable;
    logic [2:0] high_prescale_code;
    logic low_prescale_enable;
    logic [2:0] low_prescale_code;
  } dbtp_presc_s;

  // operating mode, {cascade_select, pwm_select}
  typedef enum logic [1:0] {
    DBTP_MODE0 = 2'b00,
    DBTP_MODE1 = 2'b01,
    DBTP_MODE3 = 2'b11,
    DBTP_MODE2 = 2'b10
  } dbtp_mode_e;

endpackage

// *** src/dbtp_timer.sv ***
// dual byte timer with toggle and pwm outputs behind an axi4-lite slave
// Notes on behaviour
// - low counter counts only while low_run is 1, else held at 0
// - high counter counts only while high_run is 1, else held at 0
// - low counter advances once per low prescaler output pulse only
// - high counter advances once per high prescaler output pulse only
// - low counter clears when stopped and on its match in modes 0 and 2
// - high counter clears when stopped and on its match in modes 0, 2, 3
// - low match buffer follows data while stopped, reloads at zero when running
// - high match buffer follows data while stopped, reloads at zero when running
// - each byte flags its own match on a prescaler output pulse while count equals its buffer
// - low output high while stopped, low while running with data FFH
// - high output high while stopped, low while running with data FFH
// - pwm_select 0: low output toggles on each low match
// - pwm_select 1: low output falls on overflow, rises on match
// - pwm_select 0 or cascade 1: high output toggles on each high match
// - pwm_select 1, cascade 0: high output falls on overflow, rises on match
// - cascade_select 1 makes high byte advance at low byte period
// - high zero flag set on reaching 0 while running, only software clears
// - low zero flag set on reaching 0 while running, only software clears
// - interrupt request when any zero flag and its enable are both 1
// - high prescale: disabled divides by 1, else by 2 to the code plus one
// - low prescale: disabled divides by 1, else by 2 to the code plus one
// - prescaler setting applied while running only when match buffer reloads
// - low source two cycles or events in modes 0, 2; one cycle in 1, 3
// - high source 2 cycles, 1 cycle, low match, low pwm period by mode
// - prescaler cleared when byte stops and when its counter clears
`timescale 1ns/100ps

// ==========================================================
// one timer byte: prescaler, counter, match buffer, wave output
module dbtp_byte
  import dbtp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic run,
  input wire logic src_tick,
  input wire logic clr_on_match,
  input wire logic pwm_mode,
  input wire logic [7:0] match_data,
  input wire logic [3:0] pre_set,
  output logic [7:0] count,
  output logic match_ev,
  output logic ovf_ev,
  output logic zero_ev,
  output logic wave
);

  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic [7:0] buf_reg;
  logic [7:0] buf_next;
  logic [7:0] pre_cnt_reg;
  logic [7:0] pre_cnt_next;
  logic [3:0] pre_act_reg;
  logic [3:0] pre_act_next;
  logic wave_reg;
  logic wave_next;
  logic [8:0] pre_span;
  logic [7:0] pre_last;
  logic pre_tick;
  logic clr_hit;
  logic data_full;

  // division: enable 0 gives last count 0, else 2^(code+1)-1
  assign pre_span = 9'h002 << pre_act_reg[2:0];
  assign pre_last = pre_act_reg[3] ? 8'(pre_span - 9'h001) : 8'h00;
  assign pre_tick = run & src_tick & (pre_cnt_reg == pre_last);

  // count events, all single-cycle pulses
  assign match_ev = pre_tick & (cnt_reg == buf_reg);
  assign ovf_ev = pre_tick & (cnt_reg == 8'hff);
  assign clr_hit = match_ev & clr_on_match;
  assign zero_ev = clr_hit | ovf_ev;
  assign data_full = (match_data == DBTP_DATA_FULL);

  // counter next value
  assign cnt_next = !run ? DBTP_CNT_RST :
    zero_ev ? DBTP_CNT_RST :
    pre_tick ? 8'(cnt_reg + 8'h01) : cnt_reg;

  // prescaler counter, restarted on stop and on counter clear
  assign pre_cnt_next = (!run | pre_tick | clr_hit) ? 8'h00 :
    src_tick ? 8'(pre_cnt_reg + 8'h01) : pre_cnt_reg;

  // match buffer and applied prescale follow while stopped
  assign buf_next = (!run | zero_ev) ? match_data : buf_reg;
  assign pre_act_next = (!run | zero_ev) ? pre_set : pre_act_reg;

  // waveform: forced levels first, then pwm or toggle behaviour
  always_comb begin
    wave_next = wave_reg;
    if (!run) begin
      wave_next = 1'b1;
    end else if (data_full) begin
      wave_next = 1'b0;
    end else if (pwm_mode) begin
      if (match_ev) begin
        wave_next = 1'b1;
      end else if (ovf_ev) begin
        wave_next = 1'b0;
      end
    end else if (match_ev) begin
      wave_next = ~wave_reg;
    end
  end

  // byte state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= DBTP_CNT_RST;
      buf_reg <= DBTP_DATA_RST;
      pre_cnt_reg <= 8'h00;
      pre_act_reg <= 4'h0;
      wave_reg <= 1'b1;
    end else if (clk_en) begin
      cnt_reg <= cnt_next;
      buf_reg <= buf_next;
      pre_cnt_reg <= pre_cnt_next;
      pre_act_reg <= pre_act_next;
      wave_reg <= wave_next;
    end
  end

  assign count = cnt_reg;
  assign wave = wave_reg;

endmodule

// ==========================================================
// top: registers, axi4-lite slave, source selection, interrupt
module dbtp_timer
  import dbtp_pkg::*;
#(
  parameter int ADDR_W = 32
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic event_input,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic low_wave_out,
  output logic high_wave_out,
  output logic irq_out
);

  // elaboration check: the register decode needs address bits 17..2
  if (ADDR_W < 18) begin : g_addr_check
    $error("ADDR_W too narrow for the register map");
  end

  // ==========================================================
  // register and bus state
  dbtp_ctrl_s ctrl_reg;
  dbtp_ctrl_s ctrl_next;
  dbtp_presc_s presc_reg;
  logic [7:0] ldata_reg;
  logic [7:0] hdata_reg;
  logic evsel_reg;
  logic irq_reg;
  logic half_reg;
  logic ev_s1_reg;
  logic ev_s2_reg;
  logic ev_s3_reg;
  logic aw_rdy_reg;
  logic w_rdy_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic [15:0] aw_idx_reg;
  logic [7:0] w_data_reg;
  logic w_lane_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic ar_rdy_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // ==========================================================
  // write channel handshakes; address and data in either order
  logic aw_take;
  logic w_take;
  logic aw_have;
  logic w_have;
  logic do_write;
  logic [15:0] wr_idx;
  logic [7:0] wr_data;
  logic wr_lane;
  logic aw_got_next;
  logic w_got_next;
  logic bvalid_next;
  logic wr_hit;

  assign aw_take = s_axi_awvalid & aw_rdy_reg;
  assign w_take = s_axi_wvalid & w_rdy_reg;
  assign aw_have = aw_got_reg | aw_take;
  assign w_have = w_got_reg | w_take;
  assign do_write = aw_have & w_have & ~bvalid_reg;
  assign wr_idx = aw_take ? s_axi_awaddr[17:2] : aw_idx_reg;
  assign wr_data = w_take ? s_axi_wdata[7:0] : w_data_reg;
  assign wr_lane = w_take ? s_axi_wstrb[0] : w_lane_reg;
  assign aw_got_next = aw_have & ~do_write;
  assign w_got_next = w_have & ~do_write;
  assign bvalid_next = (bvalid_reg & ~s_axi_bready) | do_write;

  // write decode; byte lane 0 carries every register
  logic wr_ctrl;
  logic wr_presc;
  logic wr_ldata;
  logic wr_hdata;
  logic wr_evsel;
  logic wr_en;

  assign wr_en = do_write & wr_lane;
  assign wr_ctrl = wr_en & (wr_idx == DBTP_IDX_CTRL);
  assign wr_presc = wr_en & (wr_idx == DBTP_IDX_PRESC);
  assign wr_ldata = wr_en & (wr_idx == DBTP_IDX_LDATA);
  assign wr_hdata = wr_en & (wr_idx == DBTP_IDX_HDATA);
  assign wr_evsel = wr_en & (wr_idx == DBTP_IDX_EVSEL);
  assign wr_hit = (wr_idx == DBTP_IDX_CTRL) | (wr_idx == DBTP_IDX_PRESC) |
    (wr_idx == DBTP_IDX_LCNT) | (wr_idx == DBTP_IDX_HCNT) |
    (wr_idx == DBTP_IDX_LDATA) | (wr_idx == DBTP_IDX_HDATA) |
    (wr_idx == DBTP_IDX_EVSEL);

  // ==========================================================
  // read channel and read data selection
  logic ar_take;
  logic rvalid_next;
  logic [15:0] rd_idx;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic [7:0] low_count;
  logic [7:0] high_count;

  assign ar_take = s_axi_arvalid & ar_rdy_reg;
  assign rvalid_next = (rvalid_reg & ~s_axi_rready) | ar_take;
  assign rd_idx = s_axi_araddr[17:2];
  assign rd_hit = (rd_idx == DBTP_IDX_CTRL) | (rd_idx == DBTP_IDX_PRESC) |
    (rd_idx == DBTP_IDX_LCNT) | (rd_idx == DBTP_IDX_HCNT) |
    (rd_idx == DBTP_IDX_LDATA) | (rd_idx == DBTP_IDX_HDATA) |
    (rd_idx == DBTP_IDX_EVSEL);
  assign rd_byte = (rd_idx == DBTP_IDX_CTRL) ? 8'(ctrl_reg) :
    (rd_idx == DBTP_IDX_PRESC) ? 8'(presc_reg) :
    (rd_idx == DBTP_IDX_LCNT) ? low_count :
    (rd_idx == DBTP_IDX_HCNT) ? high_count :
    (rd_idx == DBTP_IDX_LDATA) ? ldata_reg :
    (rd_idx == DBTP_IDX_HDATA) ? hdata_reg :
    (rd_idx == DBTP_IDX_EVSEL) ? {7'h00, evsel_reg} : 8'h00;

  // ==========================================================
  // count sources
  logic ev_edge;
  logic low_src;
  logic high_src;
  logic low_match;
  logic low_ovf;
  logic low_zero;
  logic high_zero;
  logic low_wave;
  logic high_wave;
  dbtp_mode_e mode;

  assign mode = dbtp_mode_e'({ctrl_reg.cascade_select, ctrl_reg.pwm_select});
  assign ev_edge = ev_s2_reg & ~ev_s3_reg; // rising edge of synced event pin

  // low source: half rate or events in toggle modes, full rate in pwm
  assign low_src = ctrl_reg.pwm_select ? 1'b1 :
    (evsel_reg ? ev_edge : half_reg);

  // high source chosen by mode; cascade uses low byte events
  always_comb begin
    case (mode)
      DBTP_MODE0: high_src = half_reg;
      DBTP_MODE1: high_src = 1'b1;
      DBTP_MODE2: high_src = low_match;
      DBTP_MODE3: high_src = low_ovf;
      default: high_src = 1'b0;
    endcase
  end

  // ==========================================================
  // the two timer bytes
  dbtp_byte u_low (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .run(ctrl_reg.low_run),
    .src_tick(low_src),
    .clr_on_match(~ctrl_reg.pwm_select),
    .pwm_mode(ctrl_reg.pwm_select),
    .match_data(ldata_reg),
    .pre_set({presc_reg.low_prescale_enable, presc_reg.low_prescale_code}),
    .count(low_count),
    .match_ev(low_match),
    .ovf_ev(low_ovf),
    .zero_ev(low_zero),
    .wave(low_wave)
  );

  dbtp_byte u_high (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .run(ctrl_reg.high_run),
    .src_tick(high_src),
    .clr_on_match(~(ctrl_reg.pwm_select & ~ctrl_reg.cascade_select)),
    .pwm_mode(ctrl_reg.pwm_select & ~ctrl_reg.cascade_select),
    .match_data(hdata_reg),
    .pre_set({presc_reg.high_prescale_enable, presc_reg.high_prescale_code}),
    .count(high_count),
    .match_ev(),
    .ovf_ev(),
    .zero_ev(high_zero),
    .wave(high_wave)
  );

  // control register: software write, then hardware sets win
  always_comb begin
    ctrl_next = wr_ctrl ? dbtp_ctrl_s'(wr_data) : ctrl_reg;
    if (high_zero) begin
      ctrl_next.high_zero_flag = 1'b1;
    end
    if (low_zero) begin
      ctrl_next.low_zero_flag = 1'b1;
    end
  end

  // ==========================================================
  // registers, synchroniser and divide-by-two
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= dbtp_ctrl_s'(DBTP_CTRL_RST);
      presc_reg <= dbtp_presc_s'(DBTP_PRESC_RST);
      ldata_reg <= DBTP_DATA_RST;
      hdata_reg <= DBTP_DATA_RST;
      evsel_reg <= DBTP_EVSEL_RST;
      half_reg <= 1'b0;
      ev_s1_reg <= 1'b0;
      ev_s2_reg <= 1'b0;
      ev_s3_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else if (clk_en) begin
      ctrl_reg <= ctrl_next;
      if (wr_presc) begin
        presc_reg <= dbtp_presc_s'(wr_data);
      end
      if (wr_ldata) begin
        ldata_reg <= wr_data;
      end
      if (wr_hdata) begin
        hdata_reg <= wr_data;
      end
      if (wr_evsel) begin
        evsel_reg <= wr_data[DBTP_EVSEL_BIT];
      end
      half_reg <= ~half_reg; // two-cycle tick
      ev_s1_reg <= event_input;
      ev_s2_reg <= ev_s1_reg;
      ev_s3_reg <= ev_s2_reg;
      irq_reg <= (ctrl_next.high_zero_flag & ctrl_next.high_irq_enable) |
        (ctrl_next.low_zero_flag & ctrl_next.low_irq_enable);
    end
  end

  // ==========================================================
  // axi write side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_rdy_reg <= 1'b0;
      w_rdy_reg <= 1'b0;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_idx_reg <= 16'h0000;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= DBTP_RESP_OKAY;
    end else if (clk_en) begin
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      aw_rdy_reg <= ~aw_got_next & ~bvalid_next;
      w_rdy_reg <= ~w_got_next & ~bvalid_next;
      if (aw_take) begin
        aw_idx_reg <= s_axi_awaddr[17:2];
      end
      if (w_take) begin
        w_data_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end
      bvalid_reg <= bvalid_next;
      if (do_write) begin
        bresp_reg <= wr_hit ? DBTP_RESP_OKAY : DBTP_RESP_SLVERR;
      end
    end
  end

  // axi read side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_rdy_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= DBTP_RESP_OKAY;
    end else if (clk_en) begin
      rvalid_reg <= rvalid_next;
      ar_rdy_reg <= ~rvalid_next;
      if (ar_take) begin
        rdata_reg <= {24'h00_0000, rd_byte};
        rresp_reg <= rd_hit ? DBTP_RESP_OKAY : DBTP_RESP_SLVERR;
      end
    end
  end

  // outputs, all from flip-flops
  assign s_axi_awready = aw_rdy_reg;
  assign s_axi_wready = w_rdy_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = ar_rdy_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign low_wave_out = low_wave;
  assign high_wave_out = high_wave;
  assign irq_out = irq_reg;

endmodule

// *** verif/dbtp_timer_props.sv ***
// checker for the dual byte timer ports
`timescale 1ns/100ps
module dbtp_timer_props
  import dbtp_pkg::*;
#(
  parameter int ADDR_W = 32
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic low_wave_out,
  input wire logic high_wave_out,
  input wire logic irq_out
);
  // ==========================================================
  // shadow of software settings
  logic [15:0] aw_q;
  logic [8:0] w_q;
  logic [7:0] ctl_sh;
  logic [7:0] ld_sh;
  logic wr_done;
  assign wr_done = s_axi_bvalid && s_axi_bready && w_q[8];

  // snoop completed writes so run and enable bits are known
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 16'h0000;
      w_q <= 9'h000;
      ctl_sh <= 8'h00;
      ld_sh <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr[17:2];
      if (s_axi_wvalid && s_axi_wready) w_q <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
      if (wr_done && aw_q == DBTP_IDX_CTRL) ctl_sh <= w_q[7:0];
      if (wr_done && aw_q == DBTP_IDX_LDATA) ld_sh <= w_q[7:0];
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_bdone;
    s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endsequence
  property p_wr_resp;
    s_wtake |=> s_bdone;
  endproperty
  property p_rd_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_rd_upper;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0000_00;
  endproperty
  property p_lo_stop;
    (!ctl_sh[6] && !s_axi_bvalid) [*2] |-> low_wave_out;
  endproperty
  property p_hi_stop;
    (!ctl_sh[7] && !s_axi_bvalid) [*2] |-> high_wave_out;
  endproperty
  property p_lo_full;
    (ctl_sh[6] && ld_sh == DBTP_DATA_FULL && !s_axi_bvalid) [*2] |-> !low_wave_out;
  endproperty
  property p_irq_mask;
    (!ctl_sh[2] && !ctl_sh[0] && !s_axi_bvalid) [*2] |-> !irq_out;
  endproperty
  property p_irq_fell;
    $fell(irq_out) |-> s_axi_bvalid;
  endproperty
  property p_irq_rise;
    $rose(irq_out) |-> ctl_sh[2] || ctl_sh[0] || s_axi_bvalid;
  endproperty

  a_wr_resp: assert property (p_wr_resp)
    else $error("write response not one cycle after take");
  a_rd_resp: assert property (p_rd_resp)
    else $error("read response not one cycle after take");
  a_rd_upper: assert property (p_rd_upper)
    else $error("read data upper bits not zero");
  a_lo_stop: assert property (p_lo_stop)
    else $error("low wave not high while stopped");
  a_hi_stop: assert property (p_hi_stop)
    else $error("high wave not high while stopped");
  a_lo_full: assert property (p_lo_full)
    else $error("low wave not low with full match data");
  a_irq_mask: assert property (p_irq_mask)
    else $error("irq raised with both enables off");
  a_irq_fell: assert property (p_irq_fell)
    else $error("irq dropped without a software write");
  a_irq_rise: assert property (p_irq_rise)
    else $error("irq rose without an enable");
endmodule

bind dbtp_timer dbtp_timer_props #(.ADDR_W(ADDR_W)) u_props (.*);

// *** verif/dbtp_timer_tb.sv ***
// self-checking bench for the dual byte timer
`timescale 1ns/100ps
module dbtp_timer_tb
  import dbtp_pkg::*;
;
  localparam logic [1:0] OK = DBTP_RESP_OKAY;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic clk_en = 1'b1;
  logic event_input = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0000_0000;
  logic [2:0] s_axi_awprot = 3'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [31:0] s_axi_araddr = 32'h0000_0000;
  logic [2:0] s_axi_arprot = 3'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic low_wave_out;
  logic high_wave_out;
  logic irq_out;
  logic ev_on = 1'b0;
  logic [2:0] ev_cnt = 3'h0;
  int mismatches = 0;
  int samples_checked = 0;
  int frozen_cycles = 0;
  logic [15:0] regs [6] = '{DBTP_IDX_CTRL, DBTP_IDX_PRESC, DBTP_IDX_LCNT, DBTP_IDX_HCNT,
    DBTP_IDX_LDATA, DBTP_IDX_HDATA};
  // control, prescaler, low data, high data, wave select, level, cycles at level
  logic [63:0] rows [9] = '{
    64'h4000_0300_0001_0008, 64'h400a_0300_0001_0040, 64'h8090_0004_0101_0028,
    64'h5000_0900_0000_000a, 64'h5000_0900_0001_00f6, 64'h9000_0009_0100_000a,
    64'he000_0102_0101_000c, 64'hf000_0001_0101_0200, 64'hf000_0900_0000_000a};

  dbtp_timer dut (.*);

  // clock and an 8 cycle event train
  always #2 aclk = ~aclk;
  always @(posedge aclk) begin
    ev_cnt <= ev_cnt + 3'h1;
    event_input <= ev_on & ev_cnt[2];
  end

  // ==========================================================
  // helpers
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one clock with a bound on the whole wait
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 3000) begin
      mismatches++;
      $display("ERROR wait expected done seen timeout");
      complete_run();
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= {14'h0000, a, 2'b00};
    s_axi_wdata <= {24'h0000_00, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      tick(n);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, r});
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] d, input logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= {14'h0000, a, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      tick(n);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk("rdata", s_axi_rdata, {24'h0000_00, d});
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, r});
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  function automatic logic wv(input logic hi);
    return hi ? high_wave_out : low_wave_out;
  endfunction

  // cycles that a wave spends at lvl, from a full change to the next
  task automatic per(input logic hi, input logic lvl, input logic [15:0] e);
    int n;
    int c;
    n = 0;
    c = 0;
    while (wv(hi) === lvl) tick(n);
    while (wv(hi) !== lvl) tick(n);
    while (wv(hi) === lvl) tick(c);
    chk("wave_time", {16'h0000, 16'(c)}, {16'h0000, e});
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (regs[i]) rd(regs[i], 8'h00, OK);
    rd(DBTP_IDX_EVSEL + 16'h0001, 8'h00, DBTP_RESP_SLVERR);
    wr(DBTP_IDX_EVSEL + 16'h0001, 8'h55, DBTP_RESP_SLVERR);
    wr(DBTP_IDX_LCNT, 8'h55, OK);
    rd(DBTP_IDX_LCNT, 8'h00, OK);
    wr(DBTP_IDX_PRESC, 8'ha5, OK);
    rd(DBTP_IDX_PRESC, 8'ha5, OK);
    // lane 0 strobe low: the write is answered but ignored
    s_axi_wstrb <= 4'he;
    wr(DBTP_IDX_PRESC, 8'h3c, OK);
    s_axi_wstrb <= 4'hf;
    rd(DBTP_IDX_PRESC, 8'ha5, OK);
    $display("test registers done");
    foreach (rows[i]) begin
      wr(DBTP_IDX_LDATA, rows[i][47:40], OK);
      wr(DBTP_IDX_HDATA, rows[i][39:32], OK);
      wr(DBTP_IDX_PRESC, rows[i][55:48], OK);
      wr(DBTP_IDX_CTRL, rows[i][63:56], OK);
      per(rows[i][24], rows[i][16], rows[i][15:0]);
      wr(DBTP_IDX_CTRL, 8'h00, OK);
      rd(DBTP_IDX_LCNT, 8'h00, OK);
      rd(DBTP_IDX_HCNT, 8'h00, OK);
      chk("low_wave_out", {31'h0, low_wave_out}, 32'h0000_0001);
      chk("high_wave_out", {31'h0, high_wave_out}, 32'h0000_0001);
    end
    $display("test waveform modes done");
    wr(DBTP_IDX_LDATA, 8'hff, OK);
    wr(DBTP_IDX_HDATA, 8'hff, OK);
    wr(DBTP_IDX_CTRL, 8'hc0, OK);
    repeat (4) @(posedge aclk);
    chk("low_wave_out", {31'h0, low_wave_out}, 32'h0000_0000);
    chk("high_wave_out", {31'h0, high_wave_out}, 32'h0000_0000);
    wr(DBTP_IDX_CTRL, 8'h00, OK);
    $display("test full match data done");
    wr(DBTP_IDX_LDATA, 8'h03, OK);
    wr(DBTP_IDX_HDATA, 8'h02, OK);
    wr(DBTP_IDX_CTRL, 8'h40, OK);
    repeat (20) @(posedge aclk);
    chk("irq_out", {31'h0, irq_out}, 32'h0000_0000);
    rd(DBTP_IDX_CTRL, 8'h42, OK);
    wr(DBTP_IDX_CTRL, 8'h43, OK);
    chk("irq_out", {31'h0, irq_out}, 32'h0000_0001);
    wr(DBTP_IDX_CTRL, 8'h03, OK);
    rd(DBTP_IDX_CTRL, 8'h03, OK);
    wr(DBTP_IDX_CTRL, 8'h01, OK);
    chk("irq_out", {31'h0, irq_out}, 32'h0000_0000);
    rd(DBTP_IDX_CTRL, 8'h01, OK);
    wr(DBTP_IDX_CTRL, 8'h84, OK);
    repeat (20) @(posedge aclk);
    rd(DBTP_IDX_CTRL, 8'h8c, OK);
    chk("irq_out", {31'h0, irq_out}, 32'h0000_0001);
    wr(DBTP_IDX_CTRL, 8'h0c, OK);
    wr(DBTP_IDX_CTRL, 8'h00, OK);
    chk("irq_out", {31'h0, irq_out}, 32'h0000_0000);
    $display("test flags done");
    wr(DBTP_IDX_PRESC, 8'h00, OK);
    wr(DBTP_IDX_CTRL, 8'h40, OK);
    per(1'b0, 1'b1, 16'h0008);
    wr(DBTP_IDX_LDATA, 8'h07, OK);
    per(1'b0, 1'b1, 16'h0010);
    wr(DBTP_IDX_PRESC, 8'h08, OK);
    per(1'b0, 1'b1, 16'h0020);
    // low level just began; 8 frozen cycles leave 32 of its cycles to count
    clk_en <= 1'b0;
    repeat (8) @(posedge aclk);
    clk_en <= 1'b1;
    while (low_wave_out === 1'b0) tick(frozen_cycles);
    chk("frozen_time", frozen_cycles, 32'h0000_0020);
    wr(DBTP_IDX_CTRL, 8'h00, OK);
    $display("test reload done");
    // event counting with the pwm bit kept at 0
    wr(DBTP_IDX_PRESC, 8'h00, OK);
    wr(DBTP_IDX_EVSEL, 8'h01, OK);
    rd(DBTP_IDX_EVSEL, 8'h01, OK);
    wr(DBTP_IDX_LDATA, 8'h01, OK);
    wr(DBTP_IDX_CTRL, 8'h40, OK);
    ev_on <= 1'b1;
    per(1'b0, 1'b1, 16'h0010);
    ev_on <= 1'b0;
    wr(DBTP_IDX_CTRL, 8'h00, OK);
    wr(DBTP_IDX_EVSEL, 8'h00, OK);
    $display("test events done");
    complete_run();
  end
endmodule
